// File: rtl/anexp_pkg.sv
package anexp_pkg;
	localparam int NUM_PORTS = 4;
	localparam int CLK_HZ = 20_000_000;
	// management frame layout
	localparam int PREAMBLE_ONES = 32;
	localparam int HDR_BITS = 12;
	localparam int DATA_BITS = 16;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// register map
	localparam logic [4:0] ANEXP_ADDR = 5'h06;
	localparam logic [4:0] INDCFG_ADDR = 5'h10;
	localparam logic [15:0] ANEXP_RESET = 16'h0000;
	localparam logic [15:0] INDCFG_RESET = 16'h0000;
	localparam int PAR_FAULT_BIT = 4;
	localparam int LP_NEXT_PAGE_BIT = 3;
	localparam int PAGE_RX_BIT = 1;
	localparam int LP_AN_ABLE_BIT = 0;
	localparam int USER_LSB = 12;
	localparam int USER_MSB = 15;
	localparam int TX_TUNE_BIT = 8;
	localparam int C_SEL_LSB = 6;
	localparam int B_SEL_LSB = 4;
	localparam int A_SEL_LSB = 2;
	localparam int LINK_ALG_BIT = 1;
	localparam int STRETCH_DIS_BIT = 0;
	localparam logic [15:0] INDCFG_RW_MASK = 16'hF1FF;
	// link, page and indicator stretch timing
	localparam int SAME_WORDS = 3;
	localparam int IDLE_RUN = 12;
	localparam int LINK_WINDOW_US = 1000;
	localparam int LINK_WINDOW_CYCLES = (CLK_HZ / 1_000_000) * LINK_WINDOW_US;
	localparam int ERR_LIMIT = 64;
	localparam int ERR_WINDOW = 1024;
	localparam int STRETCH_MS = 100;
	localparam int STRETCH_CYCLES = (CLK_HZ / 1000) * STRETCH_MS;

	typedef struct packed {
		logic tx_act;
		logic rx_act;
		logic half_duplex;
		logic speed100;
		logic collision;
		logic par_fault;
		logic lp_next_page;
		logic lp_an_able;
		logic cw_valid;
		logic [15:0] cw;
		logic sym_valid;
		logic sym_idle;
		logic sym_err;
	} port_in_t;

	typedef struct packed {
		logic indicator_out_c;
		logic indicator_out_b;
		logic indicator_out_a;
		logic link_up;
		logic fast_rise;
	} port_out_t;
endpackage : anexp_pkg

// File: rtl/anexp_status_led_config_regs.sv
`timescale 1ns/10ps
// Function
// [RULE_01] the parallel detection fault bit is set by a fault and held high until cleared.
// [RULE_02] the page received bit latches high after three identical consecutive code words.
// [RULE_03] the partner next page bit shows whether the partner advertises next page.
// [RULE_04] the partner auto-negotiation bit shows whether the partner can auto-negotiate.
// [RULE_05] four user bits store what is written and steer nothing.
// [RULE_06] the tuning bit drives the faster rise time control, reset value 0.
// [RULE_07] indicator c shows link, half duplex, 100 Mbps or collision by its select, reset 00.
// [RULE_08] indicator b shows receive activity, link, half duplex or 100 Mbps by its select.
// [RULE_09] indicator a shows transmit activity, receive activity, link or half duplex, reset 00.
// [RULE_10] with the algorithm bit at 1 link drops if 12 idles in a row are not seen in the window.
// [RULE_11] with the algorithm bit at 0 link drops when symbol errors exceed 64 per 1024.
// [RULE_12] indicator active time is stretched while the stretch disable bit is 0.
// [RULE_13] a read of the expansion register clears its latched bits unless the cause persists.
// [RULE_14] each of the four ports has its own registers, indicators and link logic.
module anexp_status_led_config_regs import anexp_pkg::*; #(
	parameter int NPORT = NUM_PORTS,
	parameter logic [4:0] BASE_PHY_ADDR = 5'h00,
	parameter int WIN_CYCLES = LINK_WINDOW_CYCLES,
	parameter int STRETCH_LEN = STRETCH_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire port_in_t port_in [NPORT],
	output port_out_t port_out [NPORT]
);
	if (NPORT < 1 || NPORT > 4 || WIN_CYCLES < 2 || STRETCH_LEN < 2) begin : g_chk
		$error("unsupported parameter value");
	end

	typedef enum {ST_PRE, ST_START, ST_HDR, ST_TA, ST_DATA} mgmt_state_t;
	mgmt_state_t st_q, st_d;
	logic [2:0] mdc_s_q;
	logic [1:0] mdio_s_q;
	logic [5:0] cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d;
	logic hit_q, hit_d, rd_q, rd_d;
	logic [1:0] pidx_q, pidx_d;
	logic [4:0] reg_q, reg_d;
	logic mdio_out_q, mdio_out_d, oe_n_q, oe_n_d;
	logic rd_exp_pulse, wr_cfg_pulse;
	logic mdc_rise, bit_in;
	logic [15:0] cfg_q [NPORT], cfg_d [NPORT];
	logic [NPORT-1:0] pdf_q, pdf_d, prx_q, prx_d, pg_q, pg_d;
	logic [15:0] cw_last_q [NPORT], cw_last_d [NPORT];
	logic [1:0] cw_cnt_q [NPORT], cw_cnt_d [NPORT];
	logic [31:0] win_q [NPORT], win_d [NPORT];
	logic [3:0] idle_q [NPORT], idle_d [NPORT];
	logic [NPORT-1:0] run_ok_q, run_ok_d;
	logic [10:0] err_q [NPORT], err_d [NPORT];
	logic [9:0] sym_q [NPORT], sym_d [NPORT];
	logic [31:0] str_q [NPORT][3], str_d [NPORT][3];
	port_out_t out_q [NPORT], out_d [NPORT];
	logic [15:0] exp_val [NPORT];
	logic [2:0] raw [NPORT];
	assign mdc_rise = mdc_s_q[1] & ~mdc_s_q[2];
	assign bit_in = mdio_s_q[1];
	assign mdio_out = mdio_out_q;
	assign mdio_oe_n = oe_n_q;

	// management frame receiver and read data shifter
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		hit_d = hit_q;
		rd_d = rd_q;
		pidx_d = pidx_q;
		reg_d = reg_q;
		mdio_out_d = mdio_out_q;
		oe_n_d = oe_n_q;
		rd_exp_pulse = 1'b0;
		wr_cfg_pulse = 1'b0;
		if (mdc_rise) begin
			unique case (st_q)
				ST_PRE: begin
					if (bit_in) begin
						cnt_d = (cnt_q == 6'(PREAMBLE_ONES)) ? cnt_q : cnt_q + 6'h01;
					end else begin
						st_d = (cnt_q == 6'(PREAMBLE_ONES)) ? ST_START : ST_PRE;
						cnt_d = 6'h00;
					end
				end
				ST_START: begin
					st_d = bit_in ? ST_HDR : ST_PRE;
					cnt_d = 6'h00;
				end
				ST_HDR: begin
					sh_d = {sh_q[14:0], bit_in};
					cnt_d = cnt_q + 6'h01;
					if (cnt_q == 6'(HDR_BITS - 1)) begin
						pidx_d = 2'(sh_q[8:4] - BASE_PHY_ADDR);
						reg_d = {sh_q[3:0], bit_in};
						hit_d = (sh_q[8:4] - BASE_PHY_ADDR) < 5'(NPORT);
						rd_d = (sh_q[10:9] == OP_READ);
						st_d = (sh_q[10:9] == OP_READ || sh_q[10:9] == OP_WRITE) ? ST_TA : ST_PRE;
						cnt_d = 6'h00;
					end
				end
				ST_TA: begin
					cnt_d = cnt_q + 6'h01;
					if (cnt_q == 6'h00 && rd_q && hit_q) begin
						oe_n_d = 1'b0;
						mdio_out_d = 1'b0;
						sh_d = (reg_q == ANEXP_ADDR) ? exp_val[pidx_q] :
							(reg_q == INDCFG_ADDR) ? (cfg_q[pidx_q] & INDCFG_RW_MASK) : 16'h0000;
						rd_exp_pulse = (reg_q == ANEXP_ADDR);
					end
					if (cnt_q == 6'h01) begin
						mdio_out_d = sh_q[15];
						sh_d = {sh_q[14:0], 1'b0};
						st_d = ST_DATA;
						cnt_d = 6'h00;
					end
				end
				ST_DATA: begin
					cnt_d = cnt_q + 6'h01;
					mdio_out_d = sh_q[15];
					sh_d = rd_q ? {sh_q[14:0], 1'b0} : {sh_q[14:0], bit_in};
					if (cnt_q == 6'(DATA_BITS - 1)) begin
						oe_n_d = 1'b1;
						wr_cfg_pulse = !rd_q && hit_q && reg_q == INDCFG_ADDR;
						st_d = ST_PRE;
						cnt_d = 6'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mdc_s_q <= 3'h0;
			mdio_s_q <= 2'h0;
			st_q <= ST_PRE;
			cnt_q <= 6'h00;
			sh_q <= 16'h0000;
			hit_q <= 1'b0;
			rd_q <= 1'b0;
			pidx_q <= 2'h0;
			reg_q <= 5'h00;
			mdio_out_q <= 1'b1;
			oe_n_q <= 1'b1;
		end else begin
			mdc_s_q <= {mdc_s_q[1:0], mdc};
			mdio_s_q <= {mdio_s_q[0], mdio_in};
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			hit_q <= hit_d;
			rd_q <= rd_d;
			pidx_q <= pidx_d;
			reg_q <= reg_d;
			mdio_out_q <= mdio_out_d;
			oe_n_q <= oe_n_d;
		end
	end

	// per-port status, indicator and link logic
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			exp_val[p] = ANEXP_RESET;
			exp_val[p][PAR_FAULT_BIT] = pdf_q[p];
			exp_val[p][LP_NEXT_PAGE_BIT] = port_in[p].lp_next_page; // RULE_03
			exp_val[p][PAGE_RX_BIT] = prx_q[p];
			exp_val[p][LP_AN_ABLE_BIT] = port_in[p].lp_an_able; // RULE_04
			cfg_d[p] = (wr_cfg_pulse && pidx_q == 2'(p)) ? (sh_d & INDCFG_RW_MASK) : cfg_q[p]; // RULE_05
			cw_last_d[p] = port_in[p].cw_valid ? port_in[p].cw : cw_last_q[p];
			cw_cnt_d[p] = cw_cnt_q[p];
			if (port_in[p].cw_valid) begin
				cw_cnt_d[p] = (port_in[p].cw == cw_last_q[p] && cw_cnt_q[p] != 2'h0) ?
					((cw_cnt_q[p] == 2'(SAME_WORDS)) ? cw_cnt_q[p] : cw_cnt_q[p] + 2'h1) : 2'h1;
			end
			pg_d[p] = port_in[p].cw_valid && port_in[p].cw == cw_last_q[p] && cw_cnt_q[p] >= 2'(SAME_WORDS - 1);
			// a read clears a latch, but a new event in the same cycle wins
			pdf_d[p] = (pdf_q[p] & ~(rd_exp_pulse && pidx_q == 2'(p))) | port_in[p].par_fault; // RULE_01 RULE_13
			prx_d[p] = (prx_q[p] & ~(rd_exp_pulse && pidx_q == 2'(p))) | pg_q[p]; // RULE_02 RULE_13
			out_d[p] = out_q[p];
			win_d[p] = (win_q[p] == 32'(WIN_CYCLES - 1)) ? 32'h0 : win_q[p] + 32'h1;
			idle_d[p] = idle_q[p];
			run_ok_d[p] = run_ok_q[p];
			err_d[p] = err_q[p];
			sym_d[p] = sym_q[p];
			if (cfg_q[p][LINK_ALG_BIT]) begin
				if (port_in[p].sym_valid) begin
					idle_d[p] = port_in[p].sym_idle ? ((idle_q[p] == 4'(IDLE_RUN)) ? idle_q[p] : idle_q[p] + 4'h1) : 4'h0;
				end
				// only a fresh idle symbol counts; a run left at twelve must not hold link up
				run_ok_d[p] = run_ok_q[p] | (port_in[p].sym_valid && idle_d[p] == 4'(IDLE_RUN));
				if (win_q[p] == 32'(WIN_CYCLES - 1)) begin
					out_d[p].link_up = run_ok_d[p]; // RULE_10
					run_ok_d[p] = 1'b0;
				end
			end else if (port_in[p].sym_valid) begin
				sym_d[p] = sym_q[p] + 10'h001;
				err_d[p] = err_q[p] + {10'h000, port_in[p].sym_err};
				if (sym_q[p] == 10'(ERR_WINDOW - 1)) begin
					out_d[p].link_up = !(err_d[p] > 11'(ERR_LIMIT)); // RULE_11
					err_d[p] = 11'h000;
				end
			end
			out_d[p].fast_rise = cfg_q[p][TX_TUNE_BIT]; // RULE_06
			unique case (cfg_q[p][C_SEL_LSB+:2]) // RULE_07
				2'h0: raw[p][2] = out_q[p].link_up;
				2'h1: raw[p][2] = port_in[p].half_duplex;
				2'h2: raw[p][2] = port_in[p].speed100;
				2'h3: raw[p][2] = port_in[p].collision;
			endcase
			unique case (cfg_q[p][B_SEL_LSB+:2]) // RULE_08
				2'h0: raw[p][1] = port_in[p].rx_act;
				2'h1: raw[p][1] = out_q[p].link_up;
				2'h2: raw[p][1] = port_in[p].half_duplex;
				2'h3: raw[p][1] = port_in[p].speed100;
			endcase
			unique case (cfg_q[p][A_SEL_LSB+:2]) // RULE_09
				2'h0: raw[p][0] = port_in[p].tx_act;
				2'h1: raw[p][0] = port_in[p].rx_act;
				2'h2: raw[p][0] = out_q[p].link_up;
				2'h3: raw[p][0] = port_in[p].half_duplex;
			endcase
			for (int i = 0; i < 3; i++) begin
				// stretch holds a short blip long enough for the eye to catch
				str_d[p][i] = raw[p][i] ? 32'(STRETCH_LEN) : (str_q[p][i] != 32'h0 ? str_q[p][i] - 32'h1 : 32'h0);
			end
			out_d[p].indicator_out_a = raw[p][0] | (!cfg_q[p][STRETCH_DIS_BIT] && str_q[p][0] != 32'h0); // RULE_12
			out_d[p].indicator_out_b = raw[p][1] | (!cfg_q[p][STRETCH_DIS_BIT] && str_q[p][1] != 32'h0); // RULE_12
			out_d[p].indicator_out_c = raw[p][2] | (!cfg_q[p][STRETCH_DIS_BIT] && str_q[p][2] != 32'h0); // RULE_12
		end
	end

	always_ff @(posedge clk) begin
		for (int p = 0; p < NPORT; p++) begin // RULE_14
			if (!rst_n) begin
				cfg_q[p] <= INDCFG_RESET;
				pdf_q[p] <= 1'b0;
				prx_q[p] <= 1'b0;
				pg_q[p] <= 1'b0;
				cw_last_q[p] <= 16'h0000;
				cw_cnt_q[p] <= 2'h0;
				win_q[p] <= 32'h0;
				idle_q[p] <= 4'h0;
				run_ok_q[p] <= 1'b0;
				err_q[p] <= 11'h000;
				sym_q[p] <= 10'h000;
				out_q[p] <= '0;
				for (int i = 0; i < 3; i++) str_q[p][i] <= 32'h0;
			end else begin
				cfg_q[p] <= cfg_d[p];
				pdf_q[p] <= pdf_d[p];
				prx_q[p] <= prx_d[p];
				pg_q[p] <= pg_d[p];
				cw_last_q[p] <= cw_last_d[p];
				cw_cnt_q[p] <= cw_cnt_d[p];
				win_q[p] <= win_d[p];
				idle_q[p] <= idle_d[p];
				run_ok_q[p] <= run_ok_d[p];
				err_q[p] <= err_d[p];
				sym_q[p] <= sym_d[p];
				out_q[p] <= out_d[p];
				for (int i = 0; i < 3; i++) str_q[p][i] <= str_d[p][i];
			end
			port_out[p] <= out_q[p];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence read_of_exp0;
		rd_exp_pulse && pidx_q == 2'h0;
	endsequence
	pdf_latch_a: assert property (port_in[0].par_fault ##1 !(rd_exp_pulse && pidx_q == 2'h0) |-> pdf_q[0] [*2]) // RULE_01
		else $error("fault flag not latched");
	page_rx_a: assert property (port_in[0].cw_valid && port_in[0].cw == cw_last_q[0] && cw_cnt_q[0] == 2'h2
		|=> ##1 prx_q[0]) // RULE_02
		else $error("page received not set after three words");
	exp_bits_a: assert property (read_of_exp0 |=> sh_q[LP_NEXT_PAGE_BIT] == $past(port_in[0].lp_next_page)
		&& sh_q[LP_AN_ABLE_BIT] == $past(port_in[0].lp_an_able)) // RULE_03 RULE_04
		else $error("partner ability bits wrong");
	tune_out_a: assert property ($changed(cfg_q[0][TX_TUNE_BIT]) |=> ##1 port_out[0].fast_rise == $past(cfg_q[0][TX_TUNE_BIT], 2)) // RULE_06
		else $error("tuning output does not follow bit");
	sel_c_a: assert property (cfg_q[0][C_SEL_LSB+:2] == 2'h3 && cfg_q[0][STRETCH_DIS_BIT] && $stable(cfg_q[0])
		|=> out_q[0].indicator_out_c == $past(port_in[0].collision)) // RULE_07
		else $error("indicator c select wrong");
	sel_a_a: assert property (cfg_q[0][A_SEL_LSB+:2] == 2'h0 && cfg_q[0][STRETCH_DIS_BIT] && $stable(cfg_q[0])
		|=> out_q[0].indicator_out_a == $past(port_in[0].tx_act)) // RULE_09
		else $error("indicator a select wrong");
	err_link_a: assert property (!cfg_q[0][LINK_ALG_BIT] && port_in[0].sym_valid && sym_q[0] == 10'h3FF
		&& err_q[0] > 11'(ERR_LIMIT) |=> !out_q[0].link_up) // RULE_11
		else $error("link stayed up on error rate");
	stretch_on_a: assert property (!cfg_q[0][STRETCH_DIS_BIT] && $stable(cfg_q[0]) && raw[0][0]
		##1 !raw[0][0] && !cfg_q[0][STRETCH_DIS_BIT] |=> out_q[0].indicator_out_a) // RULE_12
		else $error("indicator not stretched");
	clr_read_a: assert property (read_of_exp0 ##0 !port_in[0].par_fault |=> !pdf_q[0] || $past(port_in[0].par_fault)) // RULE_13
		else $error("fault flag not cleared by read");
endmodule : anexp_status_led_config_regs

// File: verification/mdio_host.sv
`timescale 1ns/10ps
module mdio_host (
	input wire logic clk,
	output logic mdc,
	output wire logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe_n
);
	localparam int HALF = 5;
	logic drv = 1'b1;
	logic own = 1'b1;
	initial mdc = 1'b0;
	// a line nobody drives settles to its pull-up level
	assign mdio_in = !mdio_oe_n ? mdio_out : (own ? drv : 1'b1);

	// one bit: low half with data set up, sample just before the rise, then high half
	task automatic slot(input logic b, input logic hold, output logic smp);
		@(posedge clk);
		mdc <= 1'b0;
		drv <= b;
		own <= hold;
		repeat (HALF) @(posedge clk);
		smp = mdio_in;
		mdc <= 1'b1;
		repeat (HALF - 1) @(posedge clk);
	endtask : slot

	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] frame;
		logic s;
		logic rdop;
		rdop = (op == 2'h2);
		frame = {32'hFFFFFFFF, 2'b01, op, phy, rg, rdop ? 2'b11 : 2'b10, rdop ? 16'hFFFF : wd};
		for (int i = 0; i < 64; i++) begin
			// a reader lets go of the line from the turnaround on
			slot(frame[63 - i], !(rdop && i >= 46), s);
			if (i >= 48) begin
				rd[63 - i] = s;
			end
		end
	endtask : xfer
endmodule : mdio_host

// File: verification/anexp_status_led_config_regs_tb.sv
`timescale 1ns/10ps
module anexp_status_led_config_regs_tb import anexp_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic mdc;
	logic mdio_in;
	logic mdio_out;
	logic mdio_oe_n;
	port_in_t pin [NUM_PORTS];
	port_out_t pout [NUM_PORTS];
	int errors = 0;
	int checked = 0;
	logic [15:0] rdv;
	int tab [3][4] = '{'{0, 1, 5, 2}, '{1, 5, 2, 3}, '{5, 2, 3, 4}};

	always #25 clk = ~clk;

	anexp_status_led_config_regs #(.WIN_CYCLES(50), .STRETCH_LEN(8)) i_dut (.clk(clk), .rst_n(rst_n), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .port_in(pin), .port_out(pout));
	mdio_host i_host (.clk(clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));

	task automatic conclude;
		if (errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic rd(input int p, input logic [4:0] rg, input logic [15:0] exp);
		i_host.xfer(OP_READ, 5'(p), rg, 16'h0000, rdv);
		chk(rdv, exp);
	endtask : rd

	task automatic wr(input int p, input logic [4:0] rg, input logic [15:0] d);
		i_host.xfer(OP_WRITE, 5'(p), rg, d, rdv);
	endtask : wr

	task automatic wait_link(input logic v, input int n);
		int i;
		for (i = 0; i < n && pout[0].link_up !== v; i++) @(posedge clk);
		checked++;
		if (i == n) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, pout[0].link_up, v);
			conclude();
		end
	endtask : wait_link

	task automatic sym_run(input int n, input int nerr, input logic idle);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pin[0].sym_valid <= 1'b1;
			pin[0].sym_err <= (i < nerr);
			pin[0].sym_idle <= idle;
		end
		@(posedge clk);
		pin[0].sym_valid <= 1'b0;
	endtask : sym_run

	task automatic t_reset;
		chk({11'h000, pout[0]}, 16'h0000);
		rd(0, ANEXP_ADDR, ANEXP_RESET);
		rd(0, INDCFG_ADDR, INDCFG_RESET);
	endtask : t_reset

	task automatic t_regs;
		wr(0, INDCFG_ADDR, 16'hFFFF);
		rd(0, INDCFG_ADDR, INDCFG_RW_MASK);
		chk({15'h0000, pout[0].fast_rise}, 16'h0001);
		for (int p = 1; p < NUM_PORTS; p++) begin
			chk({15'h0000, pout[p].fast_rise}, 16'h0000);
		end
		wr(0, ANEXP_ADDR, 16'hFFFF);
		rd(0, ANEXP_ADDR, 16'h0000);
		rd(0, 5'h11, 16'h0000);
		rd(1, INDCFG_ADDR, 16'h0000);
		rd(NUM_PORTS, INDCFG_ADDR, 16'hFFFF);
		wr(0, INDCFG_ADDR, 16'hA000);
		rd(0, INDCFG_ADDR, 16'hA000);
		chk({15'h0000, pout[0].fast_rise}, 16'h0000);
	endtask : t_regs

	task automatic t_link;
		wr(0, INDCFG_ADDR, 16'h0000);
		sym_run(1024, 64, 1'b0);
		wait_link(1'b1, 20);
		sym_run(1024, 65, 1'b0);
		wait_link(1'b0, 20);
		wr(0, INDCFG_ADDR, 16'h0002);
		sym_run(40, 0, 1'b1);
		wait_link(1'b1, 200);
		wait_link(1'b0, 200);
		wr(0, INDCFG_ADDR, 16'h0000);
		sym_run(1024, 0, 1'b0);
		wait_link(1'b1, 20);
	endtask : t_link

	task automatic t_sel;
		logic [5:0] eff;
		for (int s = 0; s < 4; s++) begin
			wr(0, INDCFG_ADDR, {8'h00, s[1:0], s[1:0], s[1:0], 2'b01});
			for (int k = 0; k < 6; k++) begin
				// link stays up from the previous scenario, so its source reads 1
				eff = {1'b1, 5'(6'h01 << k)};
				@(posedge clk);
				{pin[0].collision, pin[0].speed100, pin[0].half_duplex, pin[0].rx_act, pin[0].tx_act} <= eff[4:0];
				tick(3);
				chk({13'h0, pout[0].indicator_out_c, pout[0].indicator_out_b, pout[0].indicator_out_a},
					{13'h0, eff[tab[2][s]], eff[tab[1][s]], eff[tab[0][s]]});
			end
		end
	endtask : t_sel

	task automatic t_stretch;
		for (int d = 0; d < 2; d++) begin
			wr(0, INDCFG_ADDR, 16'(d));
			@(posedge clk);
			pin[0].tx_act <= 1'b1;
			@(posedge clk);
			pin[0].tx_act <= 1'b0;
			tick(5);
			chk({15'h0, pout[0].indicator_out_a}, 16'(1 - d));
			tick(10);
			chk({15'h0, pout[0].indicator_out_a}, 16'h0000);
		end
	endtask : t_stretch

	task automatic cw(input logic [15:0] w);
		@(posedge clk);
		pin[0].cw_valid <= 1'b1;
		pin[0].cw <= w;
		@(posedge clk);
		pin[0].cw_valid <= 1'b0;
	endtask : cw

	task automatic t_status;
		@(posedge clk);
		pin[0].par_fault <= 1'b1;
		pin[0].lp_next_page <= 1'b1;
		@(posedge clk);
		pin[0].par_fault <= 1'b0;
		tick(3);
		rd(0, ANEXP_ADDR, 16'h0018);
		rd(0, ANEXP_ADDR, 16'h0008);
		pin[0].lp_next_page <= 1'b0;
		pin[0].lp_an_able <= 1'b1;
		cw(16'h1234);
		cw(16'h1234);
		cw(16'h4321);
		tick(3);
		rd(0, ANEXP_ADDR, 16'h0001);
		cw(16'h4321);
		cw(16'h4321);
		tick(3);
		rd(0, ANEXP_ADDR, 16'h0003);
		rd(0, ANEXP_ADDR, 16'h0001);
	endtask : t_status

	initial begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			pin[i] = '0;
		end
		tick(4);
		rst_n <= 1'b1;
		tick(2);
		t_reset();
		t_regs();
		t_link();
		t_sel();
		t_stretch();
		t_status();
		conclude();
	end
endmodule : anexp_status_led_config_regs_tb
